// *** rtl/tbi_pkg.sv ***
// Package of constants for the transmit backplane interface block
package tbi_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_OPTIONS = 8'h42;
  localparam logic [7:0] ADDR_TIMING  = 8'h43;
  localparam logic [7:0] ADDR_SLOT    = 8'h44;
  localparam logic [7:0] ADDR_EDGE    = 8'h45;
  localparam logic [7:0] ADDR_LANE    = 8'h4c;
  localparam logic [7:0] ADDR_STATUS  = 8'h4d;
  // Writable masks
  localparam logic [7:0] MASK_OPTIONS = 8'h1f;
  localparam logic [7:0] MASK_TIMING  = 8'h01;
  localparam logic [7:0] MASK_SLOT    = 8'h7f;
  localparam logic [7:0] MASK_EDGE    = 8'h08;
  localparam logic [7:0] MASK_LANE    = 8'h07;
  // Reset values
  localparam logic [7:0] RST_OPTIONS  = 8'h00;
  localparam logic [7:0] RST_TIMING   = 8'h00;
  localparam logic [7:0] RST_SLOT     = 8'h00;
  localparam logic [7:0] RST_EDGE     = 8'h00;
  localparam logic [7:0] RST_LANE     = 8'h00;
  // Field positions
  localparam int OPT_KIND = 0;
  localparam int OPT_POL  = 1;
  localparam int OPT_DBL  = 2;
  localparam int OPT_FE   = 3;
  localparam int OPT_DE   = 4;
  localparam int TIM_SLV  = 0;
  localparam int EDGE_SEC = 3;
  localparam int LANE_MUX = 0;
  localparam int LANE_CRC = 1;
  localparam int LANE_SIG = 2;
  // Frame geometry
  localparam logic [9:0] BITS_NM  = 10'h0ff;
  localparam logic [9:0] BITS_MUX = 10'h3ff;
  localparam logic [6:0] SLOT_MAX_NM = 7'h1f;
  // Master clock divider
  localparam longint SYS_CLK_HZ   = 100_000_000;
  localparam longint LINE_RATE_HZ = 2_048_000;
  localparam int MASTER_HALF = int'(SYS_CLK_HZ / (2 * LINE_RATE_HZ));
  // Word pushed per timeslot: slot, signalling, payload
  localparam int WORD_W     = 23;
  localparam int FIFO_DEPTH = 4;
endpackage

// *** rtl/tbi_fifo_if.sv ***
// Interface carrying the slot word stream into and out of the FIFO
`timescale 1ns/10ps
`default_nettype none
interface tbi_fifo_if #(parameter int W = 8);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport fifo_mp (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport user_mp (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// *** rtl/tbi_fifo.sv ***
// Small synchronous FIFO for timeslot words
`timescale 1ns/10ps
`default_nettype none
module tbi_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic   clock,
  input wire logic   reset,
  // Stream ports
  tbi_fifo_if.fifo_mp f
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Handshakes and flags
  assign f.push_ready = (cnt_q != (AW+1)'(D));
  assign f.pop_valid  = (cnt_q != '0);
  assign f.pop_data   = mem[rd_q];
  assign push = f.push_valid & f.push_ready;
  assign pop  = f.pop_valid & f.pop_ready;

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= f.push_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** rtl/tbi_top.sv ***
// Transmit backplane interface: pin sampling, framing, slot assembly, registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module tbi_top #(
  parameter int WORD_W = tbi_pkg::WORD_W,
  parameter int DEPTH  = tbi_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Backplane pins
  input  wire logic              tx_backplane_clock_i,
  output logic                   tx_backplane_clock_o,
  output logic                   tx_backplane_clock_oe,
  input  wire logic              tx_frame_pulse_i,
  output logic                   tx_frame_pulse_o,
  output logic                   tx_frame_pulse_oe,
  input  wire logic              tx_payload_in,
  input  wire logic              tx_signalling_in,
  // Slot word stream
  output logic                   slot_valid,
  input  wire logic              slot_ready,
  output logic      [WORD_W-1:0] slot_data
);
  logic [7:0] opt_q, tim_q, off_q, edg_q, lane_q, rdata_q;
  logic [2:0] ck_s, fp_s;
  logic [1:0] pd_s, sg_s;
  logic [5:0] div_q;
  logic       mclk_q, phase_q, fp_seen_q, fp_prev_q, fp_lvl_q, fp_pin_q;
  logic       aligned_q, overrun_q, push_q, valid_q;
  logic [9:0] bit_q;
  logic [3:0] fr_q;
  logic [7:0] pay_q, sig_q;
  logic [WORD_W-1:0] word_q, data_q;
  tbi_fifo_if #(.W(WORD_W)) fq ();

  // Configuration fields
  logic payload_sample_edge_sel, frame_pulse_edge_sel, clock_double_rate_sel;
  logic frame_pulse_polarity, frame_pulse_kind, tx_timing_master_slave, mux_w;
  logic crc_gen_w, sig_gen_w, slave_w, dbl_w, rise, fall, data_ev, fp_ev, take_go;
  logic fp_act_w, mark_w, fp_new_w, hit_w, phase_w, align_w, algn_q, oe_q;
  logic [6:0] slot_offset_count;
  logic [9:0] mask_w, start_w, idx_w;
  assign payload_sample_edge_sel = opt_q[tbi_pkg::OPT_DE];
  assign frame_pulse_edge_sel    = opt_q[tbi_pkg::OPT_FE];
  assign clock_double_rate_sel   = opt_q[tbi_pkg::OPT_DBL];
  assign frame_pulse_polarity    = opt_q[tbi_pkg::OPT_POL];
  assign frame_pulse_kind        = opt_q[tbi_pkg::OPT_KIND];
  assign tx_timing_master_slave  = tim_q[tbi_pkg::TIM_SLV];
  assign mux_w     = lane_q[tbi_pkg::LANE_MUX];
  assign crc_gen_w = lane_q[tbi_pkg::LANE_CRC];
  assign sig_gen_w = lane_q[tbi_pkg::LANE_SIG];
  assign slave_w   = tx_timing_master_slave | mux_w;
  assign dbl_w     = clock_double_rate_sel & slave_w;
  assign slot_offset_count = mux_w ? off_q[6:0] : (off_q[6:0] & tbi_pkg::SLOT_MAX_NM);
  assign mask_w    = mux_w ? tbi_pkg::BITS_MUX : tbi_pkg::BITS_NM;
  assign start_w   = (10'h000 - {slot_offset_count, 3'h0}) & mask_w;

  // Edge events from the synchronised pin clock or the local divider
  assign rise    = slave_w ? (ck_s[1] & ~ck_s[2]) : (div_q == 6'(tbi_pkg::MASTER_HALF - 1) & ~mclk_q);
  assign fall    = slave_w ? (~ck_s[1] & ck_s[2]) : (div_q == 6'(tbi_pkg::MASTER_HALF - 1) & mclk_q);
  assign data_ev = payload_sample_edge_sel ? rise : fall;
  assign fp_ev   = frame_pulse_edge_sel ? rise : fall;
  assign fp_new_w = slave_w & fp_ev & fp_act_w & ~fp_prev_q;
  assign hit_w    = fp_new_w | fp_seen_q;
  assign phase_w  = hit_w ? 1'b0 : phase_q; // First active edge after a pulse is phase 0
  assign take_go = data_ev & (~dbl_w | (phase_w == edg_q[tbi_pkg::EDGE_SEC]));
  assign align_w  = take_go & (hit_w | algn_q);
  assign idx_w    = align_w ? start_w : bit_q; // Frame index of the bit taken now
  assign fp_act_w = fp_s[1] ^ frame_pulse_polarity;

  // Master pulse mark for the current bit
  always_comb begin
    mark_w = 1'b0;
    if (!frame_pulse_kind || !(crc_gen_w || sig_gen_w)) begin
      mark_w = (bit_q == start_w);
    end else begin
      mark_w = (bit_q == start_w) && (fr_q == 4'h0);
    end
  end

  // Pin synchronisers, first stage read only by the second
  always_ff @(posedge clock) begin
    if (reset) begin
      ck_s <= '0;
      fp_s <= '0;
      pd_s <= '0;
      sg_s <= '0;
    end else begin
      ck_s <= {ck_s[1:0], tx_backplane_clock_i};
      fp_s <= {fp_s[1:0], tx_frame_pulse_i};
      pd_s <= {pd_s[0], tx_payload_in};
      sg_s <= {sg_s[0], tx_signalling_in};
    end
  end

  // Register writes, reserved bits masked off
  always_ff @(posedge clock) begin
    if (reset) begin
      opt_q  <= tbi_pkg::RST_OPTIONS;
      tim_q  <= tbi_pkg::RST_TIMING;
      off_q  <= tbi_pkg::RST_SLOT;
      edg_q  <= tbi_pkg::RST_EDGE;
      lane_q <= tbi_pkg::RST_LANE;
    end else if (reg_wr) begin
      case (reg_addr)
        tbi_pkg::ADDR_OPTIONS: opt_q  <= reg_wdata & tbi_pkg::MASK_OPTIONS;
        tbi_pkg::ADDR_TIMING:  tim_q  <= reg_wdata & tbi_pkg::MASK_TIMING;
        tbi_pkg::ADDR_SLOT:    off_q  <= reg_wdata & tbi_pkg::MASK_SLOT;
        tbi_pkg::ADDR_EDGE:    edg_q  <= reg_wdata & tbi_pkg::MASK_EDGE;
        tbi_pkg::ADDR_LANE:    lane_q <= reg_wdata & tbi_pkg::MASK_LANE;
        default: ;
      endcase
    end
  end

  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset || !reg_rd) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        tbi_pkg::ADDR_OPTIONS: rdata_q <= opt_q;
        tbi_pkg::ADDR_TIMING:  rdata_q <= tim_q;
        tbi_pkg::ADDR_SLOT:    rdata_q <= off_q;
        tbi_pkg::ADDR_EDGE:    rdata_q <= edg_q;
        tbi_pkg::ADDR_LANE:    rdata_q <= lane_q;
        tbi_pkg::ADDR_STATUS:  rdata_q <= {fr_q, 1'b0, fq.pop_valid, overrun_q, aligned_q};
        default:               rdata_q <= 8'h00;
      endcase
    end
  end

  // Master clock divider, drives the pin clock
  always_ff @(posedge clock) begin
    if (reset || slave_w) begin
      div_q  <= '0;
      mclk_q <= 1'b0;
    end else if (div_q == 6'(tbi_pkg::MASTER_HALF - 1)) begin
      div_q  <= '0;
      mclk_q <= ~mclk_q;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // Frame pulse edge capture; the bit under the pulse opens the frame
  always_ff @(posedge clock) begin
    if (reset || !slave_w) begin
      fp_prev_q <= 1'b0;
      fp_seen_q <= 1'b0;
      algn_q    <= 1'b0;
    end else begin
      if (fp_ev) begin
        fp_prev_q <= fp_act_w;
      end
      if (data_ev) begin
        fp_seen_q <= 1'b0;
      end else if (fp_new_w) begin
        fp_seen_q <= 1'b1;
      end
      if (take_go) begin
        algn_q <= 1'b0;
      end else if (data_ev && hit_w) begin
        algn_q <= 1'b1; // Second sub-edge still owes the alignment
      end
    end
  end

  // Bit, frame and double-rate phase counters
  always_ff @(posedge clock) begin
    if (reset) begin
      bit_q     <= '0;
      fr_q      <= '0;
      phase_q   <= 1'b0;
      aligned_q <= 1'b0;
    end else begin
      if (data_ev && dbl_w) begin
        phase_q <= ~phase_w;
      end
      if (take_go) begin
        bit_q <= (idx_w + 10'h001) & mask_w;
        if (align_w) begin
          aligned_q <= 1'b1;
        end
        if (align_w && frame_pulse_kind && (crc_gen_w || sig_gen_w)) begin
          fr_q <= 4'h0;
        end else if (((idx_w + 10'h001) & mask_w) == 10'h000) begin
          fr_q <= fr_q + 4'h1;
        end
      end
    end
  end

  // Master frame pulse level and pin drive
  always_ff @(posedge clock) begin
    if (reset) begin
      fp_lvl_q <= 1'b0;
      fp_pin_q <= 1'b0;
    end else if (fp_ev && !slave_w) begin
      if (frame_pulse_kind && crc_gen_w && sig_gen_w) begin
        if (bit_q == start_w && fr_q == 4'h0) begin
          fp_lvl_q <= 1'b1;
          fp_pin_q <= ~frame_pulse_polarity;
        end else if (bit_q == ((start_w + 10'h001) & mask_w) && fr_q == 4'h0) begin
          fp_lvl_q <= 1'b0;
          fp_pin_q <= frame_pulse_polarity;
        end
      end else begin
        fp_lvl_q <= mark_w;
        fp_pin_q <= mark_w ^ frame_pulse_polarity;
      end
    end
  end

  // Slot assembly: payload and signalling shift in together
  always_ff @(posedge clock) begin
    if (reset) begin
      pay_q  <= '0;
      sig_q  <= '0;
      push_q <= 1'b0;
      word_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (take_go) begin
        pay_q <= {pay_q[6:0], pd_s[1]};
        sig_q <= {sig_q[6:0], sg_s[1]};
        if (idx_w[2:0] == 3'h7) begin
          push_q <= 1'b1;
          word_q <= {idx_w[9:3], sig_q[6:0], sg_s[1], pay_q[6:0], pd_s[1]};
        end
      end
    end
  end

  // Overrun flag: set wins over write-one clear
  always_ff @(posedge clock) begin
    if (reset) begin
      overrun_q <= 1'b0;
    end else if (push_q && !fq.push_ready) begin
      overrun_q <= 1'b1;
    end else if (reg_wr && reg_addr == tbi_pkg::ADDR_STATUS && reg_wdata[1]) begin
      overrun_q <= 1'b0;
    end
  end

  // FIFO and registered output stage
  assign fq.push_valid = push_q;
  assign fq.push_data  = word_q;
  assign fq.pop_ready  = ~valid_q | slot_ready;
  tbi_fifo #(.W(WORD_W), .D(DEPTH)) u_fifo (.clock(clock), .reset(reset), .f(fq));

  always_ff @(posedge clock) begin
    if (reset) begin
      valid_q <= 1'b0;
      data_q  <= '0;
    end else if (fq.pop_ready) begin
      valid_q <= fq.pop_valid;
      data_q  <= fq.pop_data;
    end
  end

  // Pin drive enable, high while the block masters clock and pulse
  always_ff @(posedge clock) begin
    if (reset) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~slave_w;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata             = rdata_q;
  assign tx_backplane_clock_o  = mclk_q;
  assign tx_backplane_clock_oe = oe_q;
  assign tx_frame_pulse_o      = fp_pin_q;
  assign tx_frame_pulse_oe     = oe_q;
  assign slot_valid            = valid_q;
  assign slot_data             = data_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sample_edge_a: assert property (take_go && slave_w |-> (payload_sample_edge_sel ? ck_s[1] && !ck_s[2] : !ck_s[1] && ck_s[2])) else $error("data edge wrong");
  pulse_edge_a: assert property (fp_ev && slave_w |-> (frame_pulse_edge_sel ? ck_s[1] && !ck_s[2] : !ck_s[1] && ck_s[2])) else $error("pulse edge wrong");
  rate_ignore_a: assert property (data_ev && !slave_w |-> take_go) else $error("double rate honoured in master");
  second_edge_a: assert property (data_ev && dbl_w && phase_w != edg_q[tbi_pkg::EDGE_SEC] |=> $stable(bit_q)) else $error("wrong edge took bit");
  pulse_pol_a: assert property (fp_ev && !slave_w && !(frame_pulse_kind && crc_gen_w && sig_gen_w) && !(reg_wr && reg_addr == tbi_pkg::ADDR_OPTIONS) |=> tx_frame_pulse_o == (fp_lvl_q ^ frame_pulse_polarity)) else $error("pulse polarity");
  basic_mark_a: assert property (fp_ev && !slave_w && !frame_pulse_kind && bit_q == start_w |=> fp_lvl_q) else $error("basic frame mark missing");
  mf_mark_a: assert property (fp_ev && !slave_w && frame_pulse_kind && (crc_gen_w ^ sig_gen_w) && fr_q != 4'h0 |=> !fp_lvl_q) else $error("multiframe mark off frame");
  both_return_a: assert property (fp_ev && !slave_w && frame_pulse_kind && crc_gen_w && sig_gen_w && fr_q == 4'h0 && bit_q == start_w |=> fp_lvl_q) else $error("toggle set missing");
  master_drive_a: assert property (!slave_w |=> tx_backplane_clock_oe && tx_frame_pulse_oe) else $error("master not driving");
  offset_align_a: assert property (align_w |=> bit_q == (($past(start_w) + 10'h001) & $past(mask_w)) && aligned_q) else $error("offset alignment");
  offset_range_a: assert property (!mux_w |-> slot_offset_count <= 7'h1f) else $error("offset out of range");
  reserved_a: assert property (reg_wr && reg_addr == tbi_pkg::ADDR_OPTIONS |=> opt_q[7:5] == 3'h0) else $error("reserved bits stored");
  align_c: cover property (slave_w && align_w);
  push_c: cover property (push_q ##[1:40] slot_valid && slot_ready);
  overrun_c: cover property (push_q && !fq.push_ready);
endmodule
`default_nettype wire

// *** bench/tbi_sys_model.sv ***
// System-side partner: drives backplane clock, frame pulse, payload and signalling
`timescale 1ns/10ps
`default_nettype none
module tbi_sys_model (
  // Backplane pins
  output logic sck,
  output logic fp,
  output logic pay,
  output logic sig
);
  // Quiet lines at time zero
  initial begin
    sck = 1'h0;
    fp  = 1'h0;
    pay = 1'h0;
    sig = 1'h0;
  end

  // Sends n slots, pulse on the first bit, bytes bp+i and bs^i MSB first; clock still outside frames
  task automatic send(input logic de, input logic pol, input logic dbl, input logic esel,
                      input int n, input logic [7:0] bp, input logic [7:0] bs);
    logic [7:0] p;
    logic [7:0] s;
    logic       bad;
    sck = !de; // Idle on the inactive level
    fp = pol;
    #203; // Idle gap; keeps every pin change after it off the system clock edge
    for (int i = 0; i < n; i++) begin
      p = bp + 8'(i);
      s = bs ^ 8'(i);
      for (int b = 7; b >= 0; b--) begin
        for (int k = 0; k < (dbl ? 2 : 1); k++) begin
          bad = dbl && (k != int'(esel)); // Wrong sub-edge sees inverted data
          pay = p[b] ^ bad;
          sig = s[b] ^ bad; // Same slot as payload
          fp = (i == 0 && b == 7) ? !pol : pol;
          #40 sck = de;
          #40 sck = !de; // Two clocks per bit at double rate
        end
      end
    end
    // Released data lines show the inverse of the last level driven
    pay = !pay;
    sig = !sig;
    fp = pol;
  endtask
endmodule
`default_nettype wire

// *** bench/tbi_top_bench.sv ***
// Self-checking testbench for the transmit backplane interface
`timescale 1ns/10ps
`default_nettype none
module tbi_top_bench;
  typedef struct packed {
    logic       de;
    logic       pol;
    logic       dbl;
    logic       esel;
    logic       mux;
    logic [6:0] off;
    logic [6:0] s0;
  } tbi_row_s;
  // Link cases: settings beside the slot number of the first word
  localparam tbi_row_s ROWS [6] = '{
    '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 7'h00},
    '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 7'h05, 7'h1b},
    '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 7'h1f, 7'h01},
    '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 7'h00, 7'h00},
    '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 7'h7f, 7'h01},
    '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 7'h40, 7'h40}};
  localparam logic [7:0] REG_A [6] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h4c, 8'h50};
  localparam logic [7:0] REG_M [6] = '{tbi_pkg::MASK_OPTIONS, tbi_pkg::MASK_TIMING, tbi_pkg::MASK_SLOT,
                                       tbi_pkg::MASK_EDGE, tbi_pkg::MASK_LANE, 8'h00};
  logic                      clock;
  logic                      reset;
  logic [7:0]                reg_addr;
  logic [7:0]                reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [7:0]                reg_rdata;
  logic                      sck;
  logic                      fp;
  logic                      pay;
  logic                      sig;
  logic                      ck_o;
  logic                      ck_oe;
  logic                      fp_o;
  logic                      fp_oe;
  logic                      slot_valid;
  logic                      slot_ready;
  logic [tbi_pkg::WORD_W-1:0] slot_data;
  logic [tbi_pkg::WORD_W-1:0] got_q[$];
  int                        miscompares = 0;
  int                        samples_checked = 0;
  int                        cycles = 0;

  tbi_top dut_u (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_backplane_clock_i(sck), .tx_backplane_clock_o(ck_o),
    .tx_backplane_clock_oe(ck_oe), .tx_frame_pulse_i(fp), .tx_frame_pulse_o(fp_o), .tx_frame_pulse_oe(fp_oe),
    .tx_payload_in(pay), .tx_signalling_in(sig), .slot_valid(slot_valid), .slot_ready(slot_ready),
    .slot_data(slot_data));
  tbi_sys_model model_u (.sck(sck), .fp(fp), .pay(pay), .sig(sig));

  // Clock generator
  initial begin
    clock = 1'h0;
    forever #5 clock = !clock;
  end

  // Collects every word taken from the stream
  always @(posedge clock) begin
    if (!reset && slot_valid === 1'h1 && slot_ready === 1'h1) begin
      got_q.push_back(slot_data);
    end
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t byte got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkw(input logic [tbi_pkg::WORD_W-1:0] g, input logic [tbi_pkg::WORD_W-1:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t word got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkn(input int g, input int e);
    samples_checked++;
    if (g != e) begin
      miscompares++;
      $display("[ERR] %0t count got %0d exp %0d", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask

  // Read strobe for one cycle, data taken in the cycle after
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 chk8(reg_rdata & m, e);
  endtask

  task automatic cfg(input tbi_row_s r);
    wr(tbi_pkg::ADDR_LANE, {7'h00, r.mux});
    wr(tbi_pkg::ADDR_TIMING, 8'h01);
    wr(tbi_pkg::ADDR_OPTIONS, {3'h0, r.de, r.de, r.dbl, r.pol, 1'h0});
    wr(tbi_pkg::ADDR_EDGE, {4'h0, r.esel, 3'h0});
    wr(tbi_pkg::ADDR_SLOT, {1'h0, r.off});
  endtask

  // Cycles until the chosen output reaches level v
  task automatic span(input logic clk_sel, input logic v, output int n);
    n = 0;
    while (((clk_sel ? ck_o : fp_o) !== v) && n < 20000) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  // Main sequence
  initial begin
    int n;
    int w;
    logic [7:0] bp;
    reset = 1'h1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    slot_ready = 1'h1;
    repeat (4) @(posedge clock);
    reset <= 1'h0;
    repeat (2) @(posedge clock);
    for (int r = 0; r < 6; r++) begin
      cfg(ROWS[r]);
      got_q.delete();
      bp = 8'(8'h1d * (r + 1));
      model_u.send(ROWS[r].de, ROWS[r].pol, ROWS[r].dbl, ROWS[r].esel, 3, bp, 8'hc3);
      repeat (50) @(posedge clock);
      chkn(got_q.size(), 3);
      for (int i = 0; i < 3 && i < got_q.size(); i++) begin
        chkw(got_q[i], {ROWS[r].s0 + 7'(i), 8'hc3 ^ 8'(i), bp + 8'(i)});
      end
    end
    // Reset in mid-run, then reset values and master mode
    @(posedge clock);
    reset <= 1'h1;
    repeat (4) @(posedge clock);
    #1 chk8({5'h00, slot_valid, ck_oe, fp_oe}, 8'h00);
    chk8(reg_rdata, 8'h00);
    @(posedge clock);
    reset <= 1'h0;
    repeat (2) @(posedge clock);
    #1 chk8({6'h00, ck_oe, fp_oe}, 8'h03);
    rdchk(tbi_pkg::ADDR_OPTIONS, 8'hff, tbi_pkg::RST_OPTIONS);
    rdchk(tbi_pkg::ADDR_TIMING, 8'hff, tbi_pkg::RST_TIMING);
    rdchk(tbi_pkg::ADDR_SLOT, 8'hff, tbi_pkg::RST_SLOT);
    wr(tbi_pkg::ADDR_OPTIONS, 8'h06);
    span(1'h1, 1'h1, n);
    span(1'h1, 1'h0, n);
    chkn(n, tbi_pkg::MASTER_HALF);
    span(1'h0, 1'h0, n);
    span(1'h0, 1'h1, w);
    chkn(w, 2 * tbi_pkg::MASTER_HALF);
    span(1'h0, 1'h0, n);
    chkn(n + w, 256 * 2 * tbi_pkg::MASTER_HALF);
    // Stalled consumer: FIFO fills and overruns, then drains
    cfg(ROWS[0]);
    repeat (8) @(posedge clock);
    slot_ready <= 1'h0;
    got_q.delete();
    model_u.send(1'h0, 1'h0, 1'h0, 1'h0, 6, 8'h40, 8'h81);
    repeat (50) @(posedge clock);
    chk8({7'h00, slot_valid}, 8'h01);
    rdchk(tbi_pkg::ADDR_STATUS, 8'h06, 8'h06);
    slot_ready <= 1'h1;
    repeat (20) @(posedge clock);
    chkn(got_q.size(), 5);
    for (int i = 0; i < 5 && i < got_q.size(); i++) begin
      chkw(got_q[i], {7'(i), 8'h81 ^ 8'(i), 8'h40 + 8'(i)});
    end
    wr(tbi_pkg::ADDR_STATUS, 8'h02);
    rdchk(tbi_pkg::ADDR_STATUS, 8'h06, 8'h00);
    // Reserved bits and an unmapped address
    for (int i = 0; i < 6; i++) begin
      wr(REG_A[i], 8'hff);
      rdchk(REG_A[i], 8'hff, REG_M[i]);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
